//--- design/dcac_pkg.sv
package dcac_pkg;
	// Register map, byte addresses on an 8-bit register port
	localparam int ADDR_W = 8;
	localparam int NCH = 2;
	localparam int CH_BIT = 5;
	localparam logic [4:0] OFS_SADDR = 5'h00;
	localparam logic [4:0] OFS_DADDR = 5'h04;
	localparam logic [4:0] OFS_DSCR = 5'h08;
	localparam logic [4:0] OFS_CHANNEL_CONTROL_A = 5'h0C;
	localparam logic [4:0] OFS_CTRLB = 5'h10;
	localparam logic [4:0] OFS_CFG = 5'h14;
	localparam logic [4:0] OFS_SPIP = 5'h18;
	localparam logic [4:0] OFS_DPIP = 5'h1C;
	localparam logic [7:0] OFS_ENA = 8'h40;
	localparam int ENA_DIS_LSB = 8;
	// Reset values
	localparam logic [31:0] CFG_RST = 32'h1000_0000;
	localparam logic [31:0] REG_RST = 32'h0000_0000;
	// Configuration fields
	localparam int CFG_SOURCE_REPLAY = 8;
	localparam int CFG_DEST_REPLAY = 12;
	localparam int CFG_SOD = 16;
	// Control A fields
	localparam int CTA_DONE = 31;
	localparam int CTA_DST_W = 28;
	localparam int CTA_SRC_W = 24;
	localparam int BTSIZE_W = 16;
	// Control B fields
	localparam int CTB_AUTO = 31;
	localparam int CTB_DST_MODE = 28;
	localparam int CTB_SRC_MODE = 24;
	localparam int CTB_DST_FOFF = 20;
	localparam int CTB_SRC_FOFF = 16;
	localparam int CTB_DST_SKIP = 12;
	localparam int CTB_SRC_SKIP = 8;
	// Skip configuration fields
	localparam int SKIP_INT_LSB = 16;
	localparam int SKIP_INT_W = 10;
	localparam int SKIP_AMT_W = 16;

	typedef enum logic [1:0] {
		MODE_INC = 2'h0,
		MODE_DEC = 2'h1,
		MODE_FIX = 2'h2
	} dcac_mode_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_XFER = 4'h2,
		ST_WBACK = 4'h4,
		ST_FETCH = 4'h8
	} dcac_state_t;

	// Descriptor as returned by the memory side
	typedef struct packed {
		logic [31:0] saddr;
		logic [31:0] daddr;
		logic [31:0] channel_control_a;
		logic [31:0] ctrlb;
		logic [31:0] next;
	} dcac_desc_t;

	// Per-channel programmable and sequencing state
	typedef struct packed {
		dcac_state_t state;
		logic [31:0] cfg;
		logic [31:0] spip;
		logic [31:0] dpip;
		logic [31:0] channel_control_a;
		logic [31:0] ctrlb;
		logic [31:0] dscr;
		logic [31:0] rep_channel_control_a;
		logic [31:0] rep_saddr;
		logic [31:0] rep_daddr;
		logic [BTSIZE_W-1:0] cnt;
		logic snap;
		logic en;
		logic xfer;
		logic fetch;
		logic wb;
		logic wbd;
	} dcac_chan_t;

	// Bytes per beat for a width code
	function automatic logic [31:0] step_bytes(input logic [1:0] w);
		step_bytes = w[1] ? 32'h0000_0004 : (w[0] ? 32'h0000_0002 : 32'h0000_0001);
	endfunction : step_bytes
endpackage : dcac_pkg

//--- design/dcac_side.sv
`timescale 1ns/10ps
`default_nettype none
module dcac_side (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic load,
	input wire logic [31:0] load_addr,
	input wire logic step,
	input wire logic [1:0] mode,
	input wire logic [1:0] width,
	input wire logic skip_en,
	input wire logic [31:0] skip_cfg,
	output logic [31:0] addr_ff
);
	import dcac_pkg::*;

	logic [31:0] nxt_addr;
	logic [31:0] stepped;
	logic [SKIP_INT_W-1:0] cnt_ff;
	logic [SKIP_INT_W-1:0] nxt_cnt;
	logic [SKIP_INT_W-1:0] cnt_inc;

	////////////////////////////////////////////////////////////////////////////
	// Address walk and skip counter
	always_comb begin
		nxt_addr = addr_ff;
		nxt_cnt = cnt_ff;
		cnt_inc = cnt_ff + 10'h001;
		case (dcac_mode_t'(mode))
			MODE_INC: stepped = addr_ff + step_bytes(width);
			MODE_DEC: stepped = addr_ff - step_bytes(width);
			default: stepped = addr_ff;
		endcase
		if (load) begin
			nxt_addr = load_addr;
			nxt_cnt = '0;
		end else if (step) begin
			nxt_addr = stepped;
			// Interval of zero matches only when the counter wraps, so the jump comes every 1024th step
			if (skip_en) begin
				if (cnt_inc == skip_cfg[SKIP_INT_LSB +: SKIP_INT_W]) begin
					nxt_addr = stepped + {16'h0000, skip_cfg[SKIP_AMT_W-1:0]};
					nxt_cnt = '0;
				end else begin
					nxt_cnt = cnt_inc;
				end
			end
		end
	end

	// Registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			addr_ff <= REG_RST;
			cnt_ff <= '0;
		end else begin
			addr_ff <= nxt_addr;
			cnt_ff <= nxt_cnt;
		end
	end
endmodule : dcac_side
`default_nettype wire

//--- design/dcac_top.sv
// Summary of operation
// - Destination fetch-off at 0 loads destination from descriptors; at 1 it does not.
// - Source mode 00 increments, 01 decrements, 10 holds the source address.
// - Destination mode 00 increments, 01 decrements, 10 holds the destination address.
// - Auto bit chains buffers without software, contiguous or replay per side.
// - Auto with source replay 0: next buffer source continues where last ended.
// - Auto with source replay 1: reload source address and control A.
// - Auto with destination replay 0: destination continues after previous buffer.
// - Auto with destination replay 1: reload destination address and control A.
// - Stop-on-completion 0: keep fetching descriptors whatever the completion flag.
// - Stop-on-completion 1: disable channel when loaded descriptor has completion set.
// - Skip interval, bits 25..16, counts transfers before the address jump.
// - At the interval, add the 16-bit skip amount to the address.
// - Destination has its own interval and amount, applied like the source.
// - Channels 0 and 1 each own an independent configuration register.
// - Skipping on a side only when its skip enable is 1.
// - At each buffer end write control A completion flag back to descriptor.
`timescale 1ns/10ps
`default_nettype none
module dcac_top (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [dcac_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [dcac_pkg::NCH-1:0] beat_ack,
	input wire logic [dcac_pkg::NCH-1:0] desc_valid,
	input wire dcac_pkg::dcac_desc_t desc_data,
	input wire logic [dcac_pkg::NCH-1:0] wb_ack,
	output logic [dcac_pkg::NCH-1:0] chan_active,
	output logic [dcac_pkg::NCH-1:0] xfer_req,
	output logic [dcac_pkg::NCH-1:0] fetch_req,
	output logic [dcac_pkg::NCH-1:0] wb_req,
	output logic [dcac_pkg::NCH-1:0] wb_done,
	output logic [dcac_pkg::NCH-1:0][31:0] desc_addr,
	output wire logic [dcac_pkg::NCH-1:0][31:0] src_addr,
	output wire logic [dcac_pkg::NCH-1:0][31:0] dst_addr
);
	import dcac_pkg::*;

	dcac_chan_t chan_ff [NCH];
	dcac_chan_t nxt_chan [NCH];
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [NCH-1:0] s_ld;
	logic [NCH-1:0] d_ld;
	logic [NCH-1:0] stp;
	logic [31:0] s_val [NCH];
	logic [31:0] d_val [NCH];

	////////////////////////////////////////////////////////////////////////////
	// Sequencing helpers

	// Open a buffer: counter cleared, start addresses captured next cycle
	function automatic dcac_chan_t chan_start(input dcac_chan_t ch);
		dcac_chan_t r;
		r = ch;
		r.state = ST_XFER;
		r.xfer = 1'b1;
		r.en = 1'b1;
		r.cnt = '0;
		r.snap = 1'b1;
		r.rep_channel_control_a = ch.channel_control_a;
		return r;
	endfunction : chan_start

	// Close the channel and drop every request
	function automatic dcac_chan_t chan_stop(input dcac_chan_t ch);
		dcac_chan_t r;
		r = ch;
		r.state = ST_IDLE;
		r.en = 1'b0;
		r.xfer = 1'b0;
		r.fetch = 1'b0;
		r.wb = 1'b0;
		return r;
	endfunction : chan_stop

	// A zero size buffer disables the channel rather than stalling it
	function automatic logic size_zero(input logic [31:0] channel_control_a);
		size_zero = (channel_control_a[BTSIZE_W-1:0] == '0);
	endfunction : size_zero

	////////////////////////////////////////////////////////////////////////////
	// Channel next state
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			nxt_chan[c] = chan_ff[c];
			s_ld[c] = 1'b0;
			d_ld[c] = 1'b0;
			stp[c] = 1'b0;
			s_val[c] = chan_ff[c].rep_saddr;
			d_val[c] = chan_ff[c].rep_daddr;
			// Software writes to this channel's own register window
			if (reg_wr && reg_addr[7:6] == 2'h0 && reg_addr[CH_BIT] == 1'(c)) begin
				case (reg_addr[4:0])
					OFS_SADDR: begin
						s_ld[c] = 1'b1;
						s_val[c] = reg_wdata;
					end
					OFS_DADDR: begin
						d_ld[c] = 1'b1;
						d_val[c] = reg_wdata;
					end
					OFS_DSCR: nxt_chan[c].dscr = reg_wdata;
					OFS_CHANNEL_CONTROL_A: nxt_chan[c].channel_control_a = reg_wdata;
					OFS_CTRLB: nxt_chan[c].ctrlb = reg_wdata;
					OFS_CFG: nxt_chan[c].cfg = reg_wdata;
					OFS_SPIP: nxt_chan[c].spip = reg_wdata;
					OFS_DPIP: nxt_chan[c].dpip = reg_wdata;
					default: ;
				endcase
			end
			case (chan_ff[c].state)
				ST_IDLE: ;
				ST_XFER: begin
					// First cycle of a buffer: remember where it began
					if (chan_ff[c].snap) begin
						nxt_chan[c].snap = 1'b0;
						nxt_chan[c].rep_saddr = src_addr[c];
						nxt_chan[c].rep_daddr = dst_addr[c];
					end
					if (beat_ack[c]) begin
						stp[c] = 1'b1;
						nxt_chan[c].cnt = chan_ff[c].cnt + 16'h0001;
						if (nxt_chan[c].cnt == chan_ff[c].channel_control_a[BTSIZE_W-1:0]) begin
							nxt_chan[c].state = ST_WBACK;
							nxt_chan[c].xfer = 1'b0;
							nxt_chan[c].wb = 1'b1;
							nxt_chan[c].wbd = chan_ff[c].channel_control_a[CTA_DONE];
						end
					end
				end
				ST_WBACK: begin
					if (wb_ack[c]) begin
						nxt_chan[c].wb = 1'b0;
						if (chan_ff[c].ctrlb[CTB_AUTO]) begin
							// Replay restores, contiguous leaves the address walking on
							if (chan_ff[c].cfg[CFG_SOURCE_REPLAY]) begin
								s_ld[c] = 1'b1;
							end
							if (chan_ff[c].cfg[CFG_DEST_REPLAY]) begin
								d_ld[c] = 1'b1;
							end
							if (chan_ff[c].cfg[CFG_SOURCE_REPLAY] || chan_ff[c].cfg[CFG_DEST_REPLAY]) begin
								nxt_chan[c].channel_control_a = chan_ff[c].rep_channel_control_a;
							end
							nxt_chan[c] = chan_start(nxt_chan[c]);
						end else if (chan_ff[c].dscr != '0) begin
							nxt_chan[c].state = ST_FETCH;
							nxt_chan[c].fetch = 1'b1;
						end else begin
							nxt_chan[c] = chan_stop(nxt_chan[c]);
						end
					end
				end
				ST_FETCH: begin
					if (desc_valid[c]) begin
						nxt_chan[c].fetch = 1'b0;
						nxt_chan[c].channel_control_a = desc_data.channel_control_a;
						nxt_chan[c].ctrlb = desc_data.ctrlb;
						nxt_chan[c].dscr = desc_data.next;
						if (!desc_data.ctrlb[CTB_SRC_FOFF]) begin
							s_ld[c] = 1'b1;
							s_val[c] = desc_data.saddr;
						end
						if (!desc_data.ctrlb[CTB_DST_FOFF]) begin
							d_ld[c] = 1'b1;
							d_val[c] = desc_data.daddr;
						end
						// Completion flag only matters with stop-on-completion set
						if ((chan_ff[c].cfg[CFG_SOD] && desc_data.channel_control_a[CTA_DONE])
							|| size_zero(desc_data.channel_control_a)) begin
							nxt_chan[c] = chan_stop(nxt_chan[c]);
						end else begin
							nxt_chan[c] = chan_start(nxt_chan[c]);
						end
					end
				end
				default: nxt_chan[c] = chan_stop(nxt_chan[c]);
			endcase
			// Enable register: evaluated last so a stop beats a same-cycle start
			if (reg_wr && reg_addr == OFS_ENA) begin
				if (reg_wdata[ENA_DIS_LSB + c]) begin
					nxt_chan[c] = chan_stop(nxt_chan[c]);
				end else if (reg_wdata[c] && nxt_chan[c].state == ST_IDLE
					&& !size_zero(nxt_chan[c].channel_control_a)) begin
					nxt_chan[c] = chan_start(nxt_chan[c]);
				end
			end
		end
	end

	// Channel registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			for (int c = 0; c < NCH; c++) begin
				chan_ff[c] <= '{state: ST_IDLE, cfg: CFG_RST, spip: REG_RST, dpip: REG_RST,
					channel_control_a: REG_RST, ctrlb: REG_RST, dscr: REG_RST, rep_channel_control_a: REG_RST,
					rep_saddr: REG_RST, rep_daddr: REG_RST, cnt: '0, default: 1'b0};
			end
		end else begin
			for (int c = 0; c < NCH; c++) begin
				chan_ff[c] <= nxt_chan[c];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Address units, one pair per channel
	for (genvar g = 0; g < NCH; g++) begin : gen_ch
		dcac_side u_src (
			.mclk(mclk),
			.resetn(resetn),
			.load(s_ld[g]),
			.load_addr(s_val[g]),
			.step(stp[g]),
			.mode(chan_ff[g].ctrlb[CTB_SRC_MODE +: 2]),
			.width(chan_ff[g].channel_control_a[CTA_SRC_W +: 2]),
			.skip_en(chan_ff[g].ctrlb[CTB_SRC_SKIP]),
			.skip_cfg(chan_ff[g].spip),
			.addr_ff(src_addr[g])
		);
		// Destination beats are counted in source beats, like the source side
		dcac_side u_dst (
			.mclk(mclk),
			.resetn(resetn),
			.load(d_ld[g]),
			.load_addr(d_val[g]),
			.step(stp[g]),
			.mode(chan_ff[g].ctrlb[CTB_DST_MODE +: 2]),
			.width(chan_ff[g].channel_control_a[CTA_DST_W +: 2]),
			.skip_en(chan_ff[g].ctrlb[CTB_DST_SKIP]),
			.skip_cfg(chan_ff[g].dpip),
			.addr_ff(dst_addr[g])
		);
		assign chan_active[g] = chan_ff[g].en;
		assign xfer_req[g] = chan_ff[g].xfer;
		assign fetch_req[g] = chan_ff[g].fetch;
		assign wb_req[g] = chan_ff[g].wb;
		assign wb_done[g] = chan_ff[g].wbd;
		assign desc_addr[g] = chan_ff[g].dscr;
	end

	////////////////////////////////////////////////////////////////////////////
	// Register read port, data one cycle after the strobe and only then
	always_comb begin
		nxt_rdata = '0;
		if (reg_rd) begin
			if (reg_addr == OFS_ENA) begin
				for (int c = 0; c < NCH; c++) begin
					nxt_rdata[c] = chan_ff[c].en;
				end
			end else if (reg_addr[7:6] == 2'h0) begin
				case (reg_addr[4:0])
					OFS_SADDR: nxt_rdata = src_addr[reg_addr[CH_BIT]];
					OFS_DADDR: nxt_rdata = dst_addr[reg_addr[CH_BIT]];
					OFS_DSCR: nxt_rdata = chan_ff[reg_addr[CH_BIT]].dscr;
					OFS_CHANNEL_CONTROL_A: nxt_rdata = chan_ff[reg_addr[CH_BIT]].channel_control_a;
					OFS_CTRLB: nxt_rdata = chan_ff[reg_addr[CH_BIT]].ctrlb;
					OFS_CFG: nxt_rdata = chan_ff[reg_addr[CH_BIT]].cfg;
					OFS_SPIP: nxt_rdata = chan_ff[reg_addr[CH_BIT]].spip;
					OFS_DPIP: nxt_rdata = chan_ff[reg_addr[CH_BIT]].dpip;
					default: nxt_rdata = '0;
				endcase
			end
		end
	end

	// Read data register
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= REG_RST;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;
endmodule : dcac_top
`default_nettype wire

//--- tb/dcac_chk.sv
`timescale 1ns/10ps
`default_nettype none
module dcac_chk
import dcac_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [dcac_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [dcac_pkg::NCH-1:0] beat_ack,
	input wire logic [dcac_pkg::NCH-1:0] desc_valid,
	input wire dcac_pkg::dcac_desc_t desc_data,
	input wire logic [dcac_pkg::NCH-1:0] wb_ack,
	input wire logic [dcac_pkg::NCH-1:0] chan_active,
	input wire logic [dcac_pkg::NCH-1:0] xfer_req,
	input wire logic [dcac_pkg::NCH-1:0] fetch_req,
	input wire logic [dcac_pkg::NCH-1:0] wb_req,
	input wire logic [dcac_pkg::NCH-1:0] wb_done,
	input wire logic [dcac_pkg::NCH-1:0][31:0] src_addr,
	input wire logic [dcac_pkg::NCH-1:0][31:0] dst_addr
);
	logic [31:0] cf0_ff, cf1_ff, ca_ff, cb_ff, sp_ff, rs_ff, rd_ff, es_ff, ed_ff;
	logic [9:0] sc_ff;
	logic xq_ff;
	wire tk = desc_valid[0] && fetch_req[0];
	wire bt = beat_ack[0] && xfer_req[0];
	wire stp = reg_wr && reg_addr == 8'h40 && reg_wdata[8];
	wire jp = cb_ff[8] && sp_ff[25:16] != 10'h0 && sc_ff + 10'h1 == sp_ff[25:16];
	function automatic logic [31:0] nx(input logic [31:0] a, input logic [1:0] m, w);
		logic [31:0] s;
		s = w[1] ? 32'h4 : (w[0] ? 32'h2 : 32'h1);
		nx = m == 2'h0 ? a + s : (m == 2'h1 ? a - s : a);
	endfunction : nx
	////////////////////////////////////////////////////////////////
	// Channel 0 shadow, plus channel 1 configuration, of what software and descriptors programmed
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cf0_ff <= CFG_RST;
			cf1_ff <= CFG_RST;
			ca_ff <= '0;
			cb_ff <= '0;
			sp_ff <= '0;
			rs_ff <= '0;
			rd_ff <= '0;
			es_ff <= '0;
			ed_ff <= '0;
			sc_ff <= '0;
			xq_ff <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == 8'h14) cf0_ff <= reg_wdata;
			if (reg_wr && reg_addr == 8'h34) cf1_ff <= reg_wdata;
			if (reg_wr && reg_addr == 8'h0C) ca_ff <= reg_wdata;
			if (reg_wr && reg_addr == 8'h10) cb_ff <= reg_wdata;
			if (reg_wr && reg_addr == 8'h18) sp_ff <= reg_wdata;
			if (tk) ca_ff <= desc_data.channel_control_a;
			if (tk) cb_ff <= desc_data.ctrlb;
			// Counter only runs while skipping is on, so other tests leave it alone
			if ((reg_wr && reg_addr == 8'h00) || (bt && jp)) sc_ff <= '0;
			else if (bt && cb_ff[8]) sc_ff <= sc_ff + 10'h1;
			es_ff <= nx(src_addr[0], cb_ff[25:24], ca_ff[25:24]) + (jp ? {16'h0, sp_ff[15:0]} : 32'h0);
			ed_ff <= nx(dst_addr[0], cb_ff[29:28], ca_ff[29:28]);
			xq_ff <= xfer_req[0];
			if (xfer_req[0] && !xq_ff) rs_ff <= src_addr[0];
			if (xfer_req[0] && !xq_ff) rd_ff <= dst_addr[0];
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence s_wbend;
		wb_ack[0] && wb_req[0] && cb_ff[31] && !stp;
	endsequence
	sequence s_take;
		tk && !(cf0_ff[16] && desc_data.channel_control_a[31]) && desc_data.channel_control_a[15:0] != 16'h0;
	endsequence
	chk_src_step: assert property (bt |=> src_addr[0] == es_ff)
		else $error("source address step wrong");
	chk_dst_step: assert property (bt && !cb_ff[12] |=> dst_addr[0] == ed_ff)
		else $error("destination address step wrong");
	chk_src_replay: assert property (s_wbend |=> src_addr[0] == (cf0_ff[8] ? rs_ff : $past(src_addr[0])))
		else $error("source address between buffers wrong");
	chk_dst_replay: assert property (s_wbend |=> dst_addr[0] == (cf0_ff[12] ? rd_ff : $past(dst_addr[0])))
		else $error("destination address between buffers wrong");
	chk_auto_next: assert property (s_wbend |=> xfer_req[0] && !fetch_req[0])
		else $error("auto mode did not chain");
	chk_keep_fetch: assert property (s_take |=> xfer_req[0] && chan_active[0])
		else $error("descriptor did not start a buffer");
	chk_stop_done: assert property (tk && cf0_ff[16] && desc_data.channel_control_a[31] |=> !chan_active[0] && !xfer_req[0])
		else $error("channel not stopped on completion flag");
	chk_dst_fetch: assert property (s_take |=> dst_addr[0] == ($past(desc_data.ctrlb[20]) ? $past(dst_addr[0]) : $past(desc_data.daddr)))
		else $error("destination load from descriptor wrong");
	chk_wb_flag: assert property ($rose(wb_req[0]) |-> wb_done[0] == ca_ff[31])
		else $error("written back completion flag wrong");
	chk_cfg_read: assert property (reg_rd && reg_addr == 8'h34 |=> reg_rdata == cf1_ff)
		else $error("channel 1 configuration read wrong");
endmodule : dcac_chk
bind dcac_top dcac_chk u_chk (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.beat_ack(beat_ack), .desc_valid(desc_valid), .desc_data(desc_data), .wb_ack(wb_ack),
	.chan_active(chan_active), .xfer_req(xfer_req), .fetch_req(fetch_req), .wb_req(wb_req),
	.wb_done(wb_done), .src_addr(src_addr), .dst_addr(dst_addr));
`default_nettype wire

//--- tb/dcac_mem.sv
`timescale 1ns/10ps
`default_nettype none
module dcac_mem
import dcac_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic slow,
	input wire dcac_pkg::dcac_desc_t d,
	input wire logic [dcac_pkg::NCH-1:0] xfer_req,
	input wire logic [dcac_pkg::NCH-1:0] fetch_req,
	input wire logic [dcac_pkg::NCH-1:0] wb_req,
	output logic [dcac_pkg::NCH-1:0] beat_ack,
	output logic [dcac_pkg::NCH-1:0] desc_valid,
	output logic [dcac_pkg::NCH-1:0] wb_ack,
	output dcac_pkg::dcac_desc_t desc_data
);
	logic tg_ff;
	// Descriptor lines show junk outside the answer cycle
	assign desc_data = |desc_valid ? d : ~d;
	// Slow mode stalls beats and descriptor answers every other cycle, like a busy memory; write-back acks are never stalled
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tg_ff <= 1'b0;
			beat_ack <= '0;
			desc_valid <= '0;
			wb_ack <= '0;
		end else begin
			tg_ff <= ~tg_ff;
			beat_ack <= xfer_req & {NCH{~(slow & tg_ff)}};
			desc_valid <= fetch_req & ~desc_valid & {NCH{~(slow & tg_ff)}};
			wb_ack <= wb_req & ~wb_ack;
		end
	end
endmodule : dcac_mem
`default_nettype wire

//--- tb/dma_channel_addressing_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dma_channel_addressing_config_tb;
	import dcac_pkg::*;
	logic mclk, resetn, reg_wr, reg_rd, slow, sk;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, seed, v, b, sp;
	logic [1:0] m, md, w;
	logic [NCH-1:0] beat_ack, desc_valid, wb_ack, chan_active, xfer_req, fetch_req, wb_req, wb_done;
	logic [NCH-1:0][31:0] desc_addr;
	wire [NCH-1:0][31:0] src_addr, dst_addr;
	dcac_desc_t d, desc_data;
	int fails, n_tests, nf, nw, n, k, c0;
	dcac_top dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .beat_ack(beat_ack),
		.desc_valid(desc_valid), .desc_data(desc_data), .wb_ack(wb_ack),
		.chan_active(chan_active), .xfer_req(xfer_req), .fetch_req(fetch_req),
		.wb_req(wb_req), .wb_done(wb_done), .desc_addr(desc_addr), .src_addr(src_addr),
		.dst_addr(dst_addr));
	dcac_mem u_mem (.mclk(mclk), .resetn(resetn), .slow(slow), .d(d), .xfer_req(xfer_req),
		.fetch_req(fetch_req), .wb_req(wb_req), .beat_ack(beat_ack), .desc_valid(desc_valid),
		.wb_ack(wb_ack), .desc_data(desc_data));
	////////////////////////////////////////////////////////////////
	// Clock and event counters
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		if (desc_valid[0] && fetch_req[0]) nf <= nf + 1;
		if (wb_ack[0] && wb_req[0]) nw <= nw + 1;
	end
	task automatic end_of_test();
		if (fails == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test
	task automatic cmp(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, g, x);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= x;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		cmp(reg_rdata, x);
	endtask : rd
	// Bounded waits; a hang counts as a mismatch
	task automatic hang(input logic f);
		k++;
		if (k > 3000) begin
			fails++;
			end_of_test();
		end
	endtask : hang
	task automatic idle();
		k = 0;
		do begin
			@(posedge mclk);
			hang(1'b0);
		end while (chan_active[0] !== 1'b0);
	endtask : idle
	function automatic logic [31:0] ex(input logic [31:0] a, input logic [1:0] mm, ww, input int nn);
		logic [31:0] s;
		s = ww[1] ? 32'h4 : (ww[0] ? 32'h2 : 32'h1);
		for (int i = 1; i <= nn; i++) begin
			a = mm == 2'h0 ? a + s : (mm == 2'h1 ? a - s : a);
			if (sk && sp[25:16] != 10'h0 && i % sp[25:16] == 0) a = a + {16'h0, sp[15:0]};
		end
		ex = a;
	endfunction : ex
	////////////////////////////////////////////////////////////////
	initial begin
		{mclk, reg_wr, reg_rd, slow, sk} = '0;
		{reg_addr, reg_wdata, d, sp} = '0;
		{fails, n_tests, nf, nw} = '0;
		seed = 32'haf828248;
		resetn = 1'b0;
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		// Reset values, unmapped place, channel independence
		rd(8'h14, CFG_RST);
		rd(8'h18, 32'h0);
		rd(8'h3C, 32'h0);
		wr(8'h60, 32'hFFFF_FFFF);
		rd(8'h60, 32'h0);
		v = CFG_RST | ($random(seed) & 32'h0001_1100);
		wr(8'h34, v);
		rd(8'h14, CFG_RST);
		rd(8'h34, v);
		// Address modes, widths and skipping on both sides
		for (int i = 0; i < 6; i++) begin
			v = $random(seed);
			{m, md, w, n, sk} = {2'(i % 3), 2'((i + 1) % 3), v[1:0], 1 + v[4:2], i > 2};
			// Memory model samples this at the edge, so drive it like any other input
			slow <= v[8];
			sp = {6'h0, 8'h0, v[10:9] + 2'h1, v[31:16]};
			b = $random(seed) & 32'hFFFF_FFFC;
			wr(8'h0C, {v[7], 1'b0, w, 2'h0, w, 8'h0, 16'(n)});
			wr(8'h10, {2'h0, md, 2'h0, m, 11'h0, sk, 3'h0, sk, 8'h0});
			wr(8'h18, sp);
			wr(8'h1C, sp);
			wr(8'h00, b);
			wr(8'h04, ~b);
			wr(8'h08, 32'h0);
			wr(8'h40, 32'h1);
			idle();
			rd(8'h00, ex(b, m, w, n));
			rd(8'h04, ex(~b, md, w, n));
		end
		// Automatic buffers, replay on one side and contiguous on the other
		sk = 1'b0;
		for (int p = 0; p < 2; p++) begin
			wr(8'h14, CFG_RST | (p ? 32'h1000 : 32'h100));
			wr(8'h0C, 32'h2200_0002);
			wr(8'h10, 32'h8000_0000);
			wr(8'h40, 32'h1);
			c0 = nw;
			k = 0;
			while (nw < c0 + 3) begin
				@(posedge mclk);
				hang(1'b0);
			end
			wr(8'h40, 32'h100);
			idle();
			rd(8'h40, 32'h0);
		end
		// Linked descriptors with and without stop on completion
		for (int p = 0; p < 2; p++) begin
			b = $random(seed) & 32'hFFFF_FFFC;
			wr(8'h14, CFG_RST | (p ? 32'h1_0000 : 32'h0));
			// Previous pass leaves a zero size from the last descriptor
			wr(8'h0C, 32'h2200_0002);
			wr(8'h10, 32'h0);
			wr(8'h04, b);
			wr(8'h08, 32'h200);
			d <= {$random(seed), ~b, 32'hA200_0002, 32'h0010_0000, 32'h300};
			c0 = nf;
			wr(8'h40, 32'h1);
			k = 0;
			while (nf == c0) begin
				@(posedge mclk);
				hang(1'b0);
			end
			d.channel_control_a <= 32'h0;
			idle();
			cmp(nf - c0, 2 - p);
			cmp(desc_addr[0], 32'h300);
			rd(8'h04, b + 32'h10 - 32'h8 * p);
		end
		end_of_test();
	end
endmodule : dma_channel_addressing_config_tb
`default_nettype wire
